// File: rtl/adcts_timing_ctrl.sv
// Conversion timing control register with AXI4-Lite access, the conversion
// clock divider and the sample phase timer it steers.
// Assumes an AXI4-Lite master on core_clk and a sequencer on the same clock.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Timing control register is eight bits wide at byte offset 0x04.
// - Any write to it aborts a running sequence and never starts one.
// - Bit 7 set gives 8-bit results with a shorter conversion; clear gives 10-bit.
// - Sampling has two phases; the first always lasts two conversion clocks.
// - Bits 6:5 set second phase to 2, 4, 8 or 16 conversion clocks.
// - Bits 4:0 divide bus clock by prescale plus one, then by two.
// - Prescale resets to 5, giving bus clock divided by 12.
module adcts_timing_ctrl
    import adcts_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              srst,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Sequencer side
    input  wire logic              seq_start,
    output adcts_cfg_s             timing_cfg,
    output logic                   conv_clk_en,
    output adcts_phase_e           seq_phase,
    output logic                   seq_busy,
    output logic                   seq_done,
    output logic                   seq_abort
);

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_TIMING,
        SEL_STATUS
    } adcts_sel_e;

    function automatic adcts_sel_e reg_sel(input logic [ADDR_W-1:0] addr);
        if (addr == TIMING_CTRL_OFS) begin
            reg_sel = SEL_TIMING;
        end else if (addr == SEQ_STATUS_OFS) begin
            reg_sel = SEL_STATUS;
        end else begin
            reg_sel = SEL_NONE;
        end
    endfunction : reg_sel

    // Write channel holding state
    logic              aw_full_q, aw_full_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic              w_full_q,  w_full_d;
    logic [31:0]       w_data_q,  w_data_d;
    logic [3:0]        w_strb_q,  w_strb_d;
    logic              bvalid_q,  bvalid_d;
    logic [1:0]        bresp_q,   bresp_d;
    logic              do_write;
    logic              wr_timing;

    always_comb begin
        s_axi_awready = !aw_full_q && !bvalid_q;
        s_axi_wready  = !w_full_q && !bvalid_q;
        do_write      = aw_full_q && w_full_q && !bvalid_q;
        wr_timing     = do_write && reg_sel(aw_addr_q) == SEL_TIMING;
        aw_full_d     = aw_full_q;
        aw_addr_d     = aw_addr_q;
        w_full_d      = w_full_q;
        w_data_d      = w_data_q;
        w_strb_d      = w_strb_q;
        bvalid_d      = bvalid_q;
        bresp_d       = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (do_write) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (reg_sel(aw_addr_q) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_full_q  <= 1'b0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            w_full_q  <= w_full_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // Timing control register and abort pulse
    adcts_cfg_s cfg_q, cfg_d;
    logic       abort_q, abort_d;

    always_comb begin
        cfg_d   = cfg_q;
        abort_d = wr_timing;
        if (wr_timing && w_strb_q[0]) begin
            cfg_d = adcts_cfg_s'(w_data_q[7:0]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_q   <= CFG_RESET;
            abort_q <= 1'b0;
        end else begin
            cfg_q   <= cfg_d;
            abort_q <= abort_d;
        end
    end

    assign timing_cfg = cfg_q;
    assign seq_abort  = abort_q;

    // Conversion clock and phase timing
    adcts_phase_e phase;

    adcts_conv_clk_div u_div (
        .core_clk (core_clk),
        .srst     (srst),
        .restart  (wr_timing),
        .prescale (cfg_q.conversion_clock_prescale),
        .conv_en  (conv_clk_en)
    );

    // A write only aborts; start comes solely from the sequencer
    adcts_sample_timer u_timer (
        .core_clk (core_clk),
        .srst     (srst),
        .conv_en  (conv_clk_en),
        .start    (seq_start),
        .abort    (wr_timing),
        .cfg      (cfg_q),
        .phase    (phase),
        .done     (seq_done)
    );

    assign seq_phase = phase;
    assign seq_busy  = (phase != PH_IDLE);

    // Read channel
    adcts_status_s status;
    logic          rvalid_q, rvalid_d;
    logic [31:0]   rdata_q,  rdata_d;
    logic [1:0]    rresp_q,  rresp_d;

    always_comb begin
        status        = '{busy: seq_busy, phase: phase};
        s_axi_arready = !rvalid_q;
        rvalid_d      = rvalid_q;
        rdata_d       = rdata_q;
        rresp_d       = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            unique case (reg_sel(s_axi_araddr))
                SEL_TIMING: rdata_d = {24'h000000, cfg_q};
                SEL_STATUS: rdata_d = {29'h00000000, status};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // Checks
    a_reg_write: assert property (@(posedge core_clk) disable iff (srst)
        do_write && aw_addr_q == 8'h04 && w_strb_q[0]
        |=> timing_cfg == $past(w_data_q[7:0]) && s_axi_bvalid)
        else $error("timing register write not stored");

    a_reg_read: assert property (@(posedge core_clk) disable iff (srst)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
        |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(cfg_q)})
        else $error("timing register read wrong");

    a_write_abort: assert property (@(posedge core_clk) disable iff (srst)
        wr_timing |=> seq_abort && seq_phase == PH_IDLE)
        else $error("write did not abort the sequence");

    a_no_restart: assert property (@(posedge core_clk) disable iff (srst)
        wr_timing |=> !seq_busy ##1 (!seq_busy || $past(seq_start)))
        else $error("write started a sequence");

    a_reset_prescale: assert property (@(posedge core_clk) disable iff (srst)
        $fell(srst) |-> timing_cfg.conversion_clock_prescale == 5'h05
        ##12 conv_clk_en)
        else $error("reset prescale not divide by twelve");

    a_resolution_out: assert property (@(posedge core_clk) disable iff (srst)
        wr_timing && w_strb_q[0]
        |=> timing_cfg.low_resolution_select == $past(w_data_q[7]))
        else $error("resolution select not applied");

    a_write_okay: assert property (@(posedge core_clk) disable iff (srst)
        do_write && aw_addr_q == TIMING_CTRL_OFS
        |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
        else $error("timing register write not answered okay");

    a_unmapped_write: assert property (@(posedge core_clk) disable iff (srst)
        do_write && aw_addr_q != TIMING_CTRL_OFS && aw_addr_q != SEQ_STATUS_OFS
        |=> s_axi_bresp == RESP_SLVERR && $stable(timing_cfg))
        else $error("unmapped write not refused");

    a_status_write: assert property (@(posedge core_clk) disable iff (srst)
        do_write && aw_addr_q == SEQ_STATUS_OFS
        |=> s_axi_bresp == RESP_OKAY && $stable(timing_cfg))
        else $error("status write had an effect");

    a_strobe_keep: assert property (@(posedge core_clk) disable iff (srst)
        wr_timing && !w_strb_q[0] |=> $stable(timing_cfg))
        else $error("write without strobe changed the register");

    a_prescale_store: assert property (@(posedge core_clk) disable iff (srst)
        wr_timing && w_strb_q[0]
        |=> timing_cfg.conversion_clock_prescale == $past(w_data_q[4:0]))
        else $error("prescale field not applied");

    a_sample_store: assert property (@(posedge core_clk) disable iff (srst)
        wr_timing && w_strb_q[0]
        |=> timing_cfg.sample_phase_length == $past(w_data_q[6:5]))
        else $error("sample length field not applied");

    a_cfg_hold: assert property (@(posedge core_clk) disable iff (srst)
        !wr_timing |=> $stable(timing_cfg))
        else $error("register changed without a write");

    a_abort_cause: assert property (@(posedge core_clk) disable iff (srst)
        seq_abort |-> $past(wr_timing))
        else $error("abort without a register write");

    a_abort_single: assert property (@(posedge core_clk) disable iff (srst)
        seq_abort |=> !seq_abort)
        else $error("abort longer than one cycle");

    a_restart_quiet: assert property (@(posedge core_clk) disable iff (srst)
        wr_timing |=> !conv_clk_en [*2])
        else $error("divider pulsed right after restart");

    a_read_hold: assert property (@(posedge core_clk) disable iff (srst)
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped before accept");

    a_resp_hold: assert property (@(posedge core_clk) disable iff (srst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before accept");

endmodule : adcts_timing_ctrl
`default_nettype wire

// File: rtl/adcts_pkg.sv
// Constants, types and helpers shared by the conversion timing control block.
// Assumes a single bus clock and a synchronous active-high reset.
package adcts_pkg;

    localparam int ADDR_W = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] TIMING_CTRL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] SEQ_STATUS_OFS  = 8'h08;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing control register layout
    typedef struct packed {
        logic       low_resolution_select;
        logic [1:0] sample_phase_length;
        logic [4:0] conversion_clock_prescale;
    } adcts_cfg_s;

    localparam logic       RES_SEL_RESET  = 1'h0;
    localparam logic [1:0] SAMPLE_LEN_RESET = 2'h0;
    localparam logic [4:0] PRESCALE_RESET = 5'h05;
    localparam adcts_cfg_s CFG_RESET = '{RES_SEL_RESET, SAMPLE_LEN_RESET, PRESCALE_RESET};

    // Timing counts in conversion clock ticks
    localparam logic [4:0] FIRST_PHASE_TICKS = 5'h02;
    localparam logic [4:0] SECOND_BASE_TICKS = 5'h02;
    localparam logic [4:0] TEN_BIT_TICKS     = 5'h0A;
    localparam logic [4:0] EIGHT_BIT_TICKS   = 5'h08;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_FIRST,
        PH_SECOND,
        PH_CONVERT
    } adcts_phase_e;

    // Status register layout
    typedef struct packed {
        logic         busy;
        adcts_phase_e phase;
    } adcts_status_s;

    function automatic logic [4:0] adcts_second_len(input logic [1:0] sample_len);
        adcts_second_len = SECOND_BASE_TICKS << sample_len;
    endfunction : adcts_second_len

    function automatic logic [4:0] adcts_conv_len(input logic low_res);
        adcts_conv_len = low_res ? EIGHT_BIT_TICKS : TEN_BIT_TICKS;
    endfunction : adcts_conv_len

endpackage : adcts_pkg

// File: rtl/adcts_conv_clk_div.sv
// Conversion clock divider: one-cycle enable every 2*(prescale+1) bus clocks.
// Assumes restart is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adcts_conv_clk_div
    import adcts_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       restart,
    input  wire logic [4:0] prescale,
    output logic            conv_en
);

    logic [5:0] cnt_q, cnt_d;
    logic       en_q, en_d;
    logic       terminal;

    always_comb begin
        terminal = (cnt_q == {prescale, 1'b1});
        cnt_d    = (restart || terminal) ? 6'h00 : cnt_q + 6'h01;
        en_d     = terminal && !restart;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_q <= 6'h00;
            en_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            en_q  <= en_d;
        end
    end

    assign conv_en = en_q;

    // Checking helpers: cycles since last pulse or restart
    logic [6:0] gap_q;
    logic       from_pulse_q;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gap_q        <= 7'h01;
            from_pulse_q <= 1'b0;
        end else begin
            gap_q        <= (en_q || restart) ? 7'h01 : gap_q + 7'h01;
            from_pulse_q <= restart ? 1'b0 : (en_q ? 1'b1 : from_pulse_q);
        end
    end

    a_div_period: assert property (@(posedge core_clk) disable iff (srst)
        en_q && from_pulse_q |-> gap_q == ({2'h0, prescale} + 7'h01) << 1)
        else $error("conversion clock period wrong");

    a_div_restart: assert property (@(posedge core_clk) disable iff (srst)
        en_q && !from_pulse_q |-> gap_q == ({2'h0, prescale} << 1) + 7'h03)
        else $error("divider did not restart");

endmodule : adcts_conv_clk_div
`default_nettype wire

// File: rtl/adcts_sample_timer.sv
// Sample and conversion phase timer driven by conversion clock ticks.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adcts_sample_timer
    import adcts_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       conv_en,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire adcts_cfg_s cfg,
    output adcts_phase_e    phase,
    output logic            done
);

    adcts_phase_e state_q, state_d;
    logic [4:0]   cnt_q, cnt_d;
    logic         done_q, done_d;
    logic [4:0]   len;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        done_d  = 1'b0;
        len     = FIRST_PHASE_TICKS;
        unique case (state_q)
            PH_IDLE:    len = FIRST_PHASE_TICKS;
            PH_FIRST:   len = FIRST_PHASE_TICKS;
            PH_SECOND:  len = adcts_second_len(cfg.sample_phase_length);
            PH_CONVERT: len = adcts_conv_len(cfg.low_resolution_select);
        endcase
        if (abort) begin
            state_d = PH_IDLE;
            cnt_d   = 5'h00;
        end else if (state_q == PH_IDLE) begin
            if (start) begin
                state_d = PH_FIRST;
                cnt_d   = 5'h00;
            end
        end else if (conv_en) begin
            if (cnt_q == len - 5'h01) begin
                cnt_d = 5'h00;
                unique case (state_q)
                    PH_FIRST:   state_d = PH_SECOND;
                    PH_SECOND:  state_d = PH_CONVERT;
                    PH_CONVERT: begin
                        state_d = PH_IDLE;
                        done_d  = 1'b1;
                    end
                    PH_IDLE:    state_d = PH_IDLE;
                endcase
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= PH_IDLE;
            cnt_q   <= 5'h00;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            done_q  <= done_d;
        end
    end

    assign phase = state_q;
    assign done  = done_q;

    // Checking helper: ticks seen in the current phase
    logic [4:0] tick_q;
    always_ff @(posedge core_clk) begin
        if (srst || state_q != state_d) begin
            tick_q <= 5'h00;
        end else begin
            tick_q <= tick_q + {4'h0, conv_en};
        end
    end

    a_first_phase: assert property (@(posedge core_clk) disable iff (srst)
        state_q == PH_FIRST && state_d == PH_SECOND |-> tick_q == 5'h01)
        else $error("first sample phase not two ticks");

    a_second_phase: assert property (@(posedge core_clk) disable iff (srst)
        state_q == PH_SECOND && state_d == PH_CONVERT
        |-> tick_q + 5'h01 == (5'h02 << cfg.sample_phase_length))
        else $error("second sample phase length wrong");

    a_conv_length: assert property (@(posedge core_clk) disable iff (srst)
        state_q == PH_CONVERT && conv_en && state_d == PH_IDLE && !abort
        |-> tick_q == (cfg.low_resolution_select ? 5'h07 : 5'h09) ##1 done)
        else $error("conversion length wrong");

endmodule : adcts_sample_timer
`default_nettype wire

// File: tb/adcts_timing_ctrl_test.sv
// Self-checking bench for the conversion timing control block.
// Assumes the block answers AXI4-Lite on core_clk and the bench plays master and sequencer.
`timescale 1ns/1ps
`default_nettype none
module adcts_timing_ctrl_test;
    import adcts_pkg::*;

    logic              core_clk;
    logic              srst;
    logic [ADDR_W-1:0] s_axi_awaddr;
    logic              s_axi_awvalid;
    logic              s_axi_awready;
    logic [31:0]       s_axi_wdata;
    logic [3:0]        s_axi_wstrb;
    logic              s_axi_wvalid;
    logic              s_axi_wready;
    logic [1:0]        s_axi_bresp;
    logic              s_axi_bvalid;
    logic              s_axi_bready;
    logic [ADDR_W-1:0] s_axi_araddr;
    logic              s_axi_arvalid;
    logic              s_axi_arready;
    logic [31:0]       s_axi_rdata;
    logic [1:0]        s_axi_rresp;
    logic              s_axi_rvalid;
    logic              s_axi_rready;
    logic              seq_start;
    adcts_cfg_s        timing_cfg;
    logic              conv_clk_en;
    adcts_phase_e      seq_phase;
    logic              seq_busy;
    logic              seq_done;
    logic              seq_abort;
    int                errors;
    int                n_checks;
    int                n_abort;
    int                n_done;

    adcts_timing_ctrl uut (
        .core_clk      (core_clk),
        .srst          (srst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .seq_start     (seq_start),
        .timing_cfg    (timing_cfg),
        .conv_clk_en   (conv_clk_en),
        .seq_phase     (seq_phase),
        .seq_busy      (seq_busy),
        .seq_done      (seq_done),
        .seq_abort     (seq_abort)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Pulse counters for abort and done
    always @(posedge core_clk) begin
        if (srst === 1'b0 && seq_abort === 1'b1) n_abort++;
        if (srst === 1'b0 && seq_done === 1'b1) n_done++;
    end

    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        logic aw_t;
        logic w_t;
        logic b_t;
        int   n;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        b_t = 1'b0;
        n = 0;
        while (!b_t && n < 100) begin
            @(negedge core_clk);
            aw_t = s_axi_awvalid && (s_axi_awready === 1'b1);
            w_t  = s_axi_wvalid && (s_axi_wready === 1'b1);
            b_t  = (s_axi_bvalid === 1'b1);
            resp = s_axi_bresp;
            n++;
            @(posedge core_clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (b_t) s_axi_bready <= 1'b0;
        end
        if (!b_t) errors++;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar_t;
        logic r_t;
        int   n;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        r_t = 1'b0;
        n = 0;
        while (!r_t && n < 100) begin
            @(negedge core_clk);
            ar_t = s_axi_arvalid && (s_axi_arready === 1'b1);
            r_t  = (s_axi_rvalid === 1'b1);
            d    = s_axi_rdata;
            resp = s_axi_rresp;
            n++;
            @(posedge core_clk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (r_t) s_axi_rready <= 1'b0;
        end
        if (!r_t) errors++;
    endtask : axi_read

    // Cycles until the next conversion clock pulse
    task automatic wait_en(output int cyc);
        cyc = 0;
        do begin
            @(negedge core_clk);
            cyc++;
        end while (conv_clk_en !== 1'b1 && cyc < 200);
    endtask : wait_en

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        int          c;
        check({24'h0, timing_cfg}, {24'h0, CFG_RESET});
        axi_read(8'h04, d, r);
        check(d, 32'h0000_0005);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        wait_en(c);
        wait_en(c);
        check(c, 12);
    endtask : t_reset

    task automatic t_divider;
        logic [1:0] r;
        int         c;
        axi_write(8'h04, 8'h1F, 4'h1, r);
        wait_en(c);
        wait_en(c);
        check(c, 64);
        axi_write(8'h04, 8'h00, 4'h1, r);
        wait_en(c);
        check(c, 2);
        wait_en(c);
        check(c, 2);
    endtask : t_divider

    task automatic run_seq(input logic lr, input logic [1:0] slen);
        logic [1:0] r;
        int         n[4];
        int         k;
        n = '{0, 0, 0, 0};
        axi_write(8'h04, {lr, slen, 5'h00}, 4'h1, r);
        check({24'h0, timing_cfg}, {24'h0, lr, slen, 5'h00});
        seq_start <= 1'b1;
        @(posedge core_clk);
        seq_start <= 1'b0;
        k = 0;
        do begin
            @(negedge core_clk);
            if (conv_clk_en === 1'b1) n[seq_phase]++;
            if (seq_busy !== (seq_phase != PH_IDLE)) errors++;
            k++;
        end while (seq_done !== 1'b1 && k < 400);
        check(seq_phase, PH_IDLE);
        check(n[PH_FIRST], 2);
        check(n[PH_SECOND], 2 << slen);
        check(n[PH_CONVERT], lr ? 8 : 10);
    endtask : run_seq

    task automatic t_abort;
        logic [31:0] d;
        logic [1:0] r;
        int         a;
        int         dn;
        int         k;
        axi_write(8'h04, 8'h60, 4'h1, r);
        seq_start <= 1'b1;
        @(posedge core_clk);
        seq_start <= 1'b0;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (seq_phase !== PH_SECOND && k < 100);
        axi_read(8'h08, d, r);
        check(d, 32'h0000_0006);
        a = n_abort;
        dn = n_done;
        axi_write(8'h04, 8'hFF, 4'h0, r);
        // Let the pulse counters see the abort edge
        @(negedge core_clk);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        check(n_abort, a + 1);
        check(seq_phase, PH_IDLE);
        check({24'h0, timing_cfg}, 32'h0000_0060);
        repeat (40) @(negedge core_clk);
        check(seq_phase, PH_IDLE);
        check(n_done, dn);
    endtask : t_abort

    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(8'h10, 8'h3C, 4'h1, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_write(8'h08, 8'h3C, 4'h1, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        check({24'h0, timing_cfg}, 32'h0000_0060);
        axi_read(8'h10, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_write(8'h04, 8'hAB, 4'h1, r);
        axi_read(8'h04, d, r);
        check(d, 32'h0000_00AB);
    endtask : t_unmapped

    initial begin
        #400000;
        errors++;
        close_out();
    end

    initial begin
        srst          = 1'b1;
        s_axi_awaddr  = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = '0;
        s_axi_wstrb   = '0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        seq_start     = 1'b0;
        errors        = 0;
        n_checks      = 0;
        n_abort       = 0;
        n_done        = 0;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
        t_divider();
        for (int i = 0; i < 8; i++) begin
            run_seq(i[2], i[1:0]);
        end
        t_abort();
        t_unmapped();
        close_out();
    end

endmodule : adcts_timing_ctrl_test
`default_nettype wire
